// ==== common/sxu_pkg.sv ====
// Shared constants, types and helpers for the subtract execution unit.
// Assumes the decoder presents one opcode word plus the first extension word.
package sxu_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Widths and opcode field positions
    localparam int unsigned DATA_W = 32;
    localparam int unsigned GRP_MSB = 15;
    localparam int unsigned GRP_LSB = 14;
    localparam int unsigned OPC_BW_MSB = 13;
    localparam int unsigned OPC_BW_LSB = 9;
    localparam int unsigned OPC_L_LSB = 8;
    localparam int unsigned SIZE_BIT = 8;
    localparam int unsigned SRC_MSB = 7;
    localparam int unsigned SRC_LSB = 4;
    localparam int unsigned DST_MSB = 3;
    localparam int unsigned DST_LSB = 0;
    localparam int unsigned SEG_FORM_BIT = 15;

    ////////////////////////////////////////////////////////////////////////////
    // Opcode encodings
    localparam logic [1:0] GRP_REG = 2'h2;
    localparam logic [1:0] GRP_IMM_PTR = 2'h0;
    localparam logic [1:0] GRP_DIR_IDX = 2'h1;
    localparam logic [4:0] OPC_BW = 5'h01;
    localparam logic [5:0] OPC_LONG = 6'h12;
    localparam logic [3:0] FIELD_ZERO = 4'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Execution times in cycles, byte/word and long
    localparam logic [4:0] CYC_REG_BW = 5'h04;
    localparam logic [4:0] CYC_REG_L = 5'h08;
    localparam logic [4:0] CYC_LIT_BW = 5'h07;
    localparam logic [4:0] CYC_LIT_L = 5'h0e;
    localparam logic [4:0] CYC_PTR_BW = 5'h07;
    localparam logic [4:0] CYC_PTR_L = 5'h0e;
    localparam logic [4:0] CYC_DIR_NS_BW = 5'h09;
    localparam logic [4:0] CYC_DIR_SS_BW = 5'h0a;
    localparam logic [4:0] CYC_DIR_SL_BW = 5'h0c;
    localparam logic [4:0] CYC_DIR_NS_L = 5'h0f;
    localparam logic [4:0] CYC_DIR_SS_L = 5'h10;
    localparam logic [4:0] CYC_DIR_SL_L = 5'h12;
    localparam logic [4:0] CYC_IDX_NS_BW = 5'h0a;
    localparam logic [4:0] CYC_IDX_SS_BW = 5'h0a;
    localparam logic [4:0] CYC_IDX_SL_BW = 5'h0d;
    localparam logic [4:0] CYC_IDX_NS_L = 5'h10;
    localparam logic [4:0] CYC_IDX_SS_L = 5'h10;
    localparam logic [4:0] CYC_IDX_SL_L = 5'h13;
    localparam logic [4:0] CNT_LAST = 5'h01;

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {
        SZ_BYTE = 2'b00,
        SZ_WORD = 2'b01,
        SZ_LONG = 2'b10
    } sxu_size_type;

    typedef enum logic [2:0] {
        SRC_REG_MODE = 3'b000,
        LITERAL_OPERAND_MODE = 3'b001,
        POINTER_REG_MODE = 3'b010,
        DIRECT_ADDRESS_MODE = 3'b011,
        INDEXED_MODE = 3'b100
    } sxu_src_type;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_BUSY = 1'b1
    } sxu_state_type;

    typedef struct packed {
        logic c;
        logic z;
        logic s;
        logic v;
        logic d;
        logic h;
    } sxu_flags_type;

    typedef struct packed {
        logic en;
        logic [3:0] dst;
        sxu_size_type size;
        logic [DATA_W-1:0] data;
    } sxu_write_type;

    typedef struct packed {
        logic legal;
        sxu_src_type mode;
        sxu_size_type size;
        logic [3:0] dst;
        logic [4:0] cycles;
    } sxu_decode_type;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [DATA_W-1:0] size_mask(input logic [DATA_W-1:0] val, input sxu_size_type sz);
        logic [DATA_W-1:0] res;
        res = val;
        if (sz == SZ_BYTE)
        begin
            res = {24'h000000, val[7:0]};
        end
        else if (sz == SZ_WORD)
        begin
            res = {16'h0000, val[15:0]};
        end
        return res;
    endfunction : size_mask

    function automatic logic size_msb(input logic [DATA_W-1:0] val, input sxu_size_type sz);
        logic res;
        res = val[31];
        if (sz == SZ_BYTE)
        begin
            res = val[7];
        end
        else if (sz == SZ_WORD)
        begin
            res = val[15];
        end
        return res;
    endfunction : size_msb

endpackage : sxu_pkg

// ==== rtl/sxu_adder.sv ====
// Adder datapath for the subtract unit: destination plus inverted source plus one.
// Purely combinational; the caller registers its outputs.
`timescale 1ns/1ps
module sxu_adder
(
    // Operands
    input wire logic [31:0] i_a,
    input wire logic [31:0] i_b,
    input wire sxu_pkg::sxu_size_type i_size,
    // Result
    output logic [31:0] o_diff,
    output sxu_pkg::sxu_flags_type o_flags
);

    logic [32:0] sum;
    logic [4:0] nib;
    logic cout;
    logic [31:0] res;

    ////////////////////////////////////////////////////////////////////////////
    // Subtraction by two's complement addition
    always_comb
    begin
        sum = {1'b0, sxu_pkg::size_mask(i_a, i_size)} + {1'b0, sxu_pkg::size_mask(~i_b, i_size)} + 33'h000000001; // RL2
        nib = {1'b0, i_a[3:0]} + {1'b0, ~i_b[3:0]} + 5'h01;
        res = sxu_pkg::size_mask(sum[31:0], i_size); // RL1
        case (i_size)
            sxu_pkg::SZ_BYTE: cout = sum[8];
            sxu_pkg::SZ_WORD: cout = sum[16];
            default: cout = sum[32];
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flags; D and H only matter for byte operation
    always_comb
    begin
        o_diff = res;
        o_flags.c = ~cout; // RL3
        o_flags.z = (res == 32'h00000000); // RL4
        o_flags.s = sxu_pkg::size_msb(res, i_size); // RL5
        o_flags.v = (sxu_pkg::size_msb(i_a, i_size) != sxu_pkg::size_msb(i_b, i_size))
                    && (sxu_pkg::size_msb(res, i_size) == sxu_pkg::size_msb(i_b, i_size)); // RL6
        o_flags.d = 1'b1; // RL7
        o_flags.h = ~nib[4]; // RL8
    end

endmodule : sxu_adder

// ==== rtl/sxu_core.sv ====
// Subtract execution unit: decodes the subtract opcode forms, times execution,
// writes the difference to the destination register and produces the flags.
// Assumes the operand fetch path presents both operand values with the start pulse.
// Function
// (RL1) Destination gets destination minus source, source untouched
// (RL2) Subtract by adding source's two's complement
// (RL3) Carry cleared on carry out, else set
// (RL4) Zero set when sized result is zero
// (RL5) Sign follows sized result's top bit
// (RL6) Overflow: opposite signs, result sign equals source
// (RL7) Decimal-adjust set for byte, else unchanged
// (RL8) Byte half-carry signals low nibble borrow
// (RL9) Destination is always a register field
// (RL10) Register form 4 cycles, long 8
// (RL11) Immediate form 7 cycles, long 14
// (RL12) Pointer register form 7 cycles, long 14
// (RL13) Direct form 9/10/12, long 15/16/18
// (RL14) Indexed form 10/10/13, long 16/16/19
// (RL15) Size bit one means word, zero byte
// (RL16) Segmented address top bit picks long form
`timescale 1ns/1ps
module sxu_core
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    // Decoder side
    input wire logic i_start,
    input wire logic [15:0] i_instr,
    input wire logic [15:0] i_ext_word,
    input wire logic i_seg_mode,
    // Operand values
    input wire logic [31:0] i_dst_val,
    input wire logic [31:0] i_src_val,
    // Status
    output logic o_busy,
    output logic o_done,
    output logic o_illegal,
    output sxu_pkg::sxu_src_type o_src_mode,
    // Register file and flag register
    output sxu_pkg::sxu_write_type o_wr,
    output sxu_pkg::sxu_flags_type o_flags,
    output logic o_flags_we,
    output logic o_dh_we
);

    ////////////////////////////////////////////////////////////////////////////
    // Decode
    function automatic sxu_pkg::sxu_decode_type decode(input logic [15:0] ins, input logic [15:0] ext,
                                                       input logic seg);
        sxu_pkg::sxu_decode_type d;
        logic [1:0] grp;
        logic is_bw;
        logic is_long;
        logic zero_src;
        logic seg_long;
        grp = ins[sxu_pkg::GRP_MSB:sxu_pkg::GRP_LSB];
        is_bw = (ins[sxu_pkg::OPC_BW_MSB:sxu_pkg::OPC_BW_LSB] == sxu_pkg::OPC_BW);
        is_long = (ins[sxu_pkg::OPC_BW_MSB:sxu_pkg::OPC_L_LSB] == sxu_pkg::OPC_LONG);
        zero_src = (ins[sxu_pkg::SRC_MSB:sxu_pkg::SRC_LSB] == sxu_pkg::FIELD_ZERO);
        seg_long = ext[sxu_pkg::SEG_FORM_BIT]; // RL16
        d.legal = (is_bw || is_long) && (grp != 2'h3);
        d.dst = ins[sxu_pkg::DST_MSB:sxu_pkg::DST_LSB]; // RL9
        if (is_long)
        begin
            d.size = sxu_pkg::SZ_LONG;
        end
        else if (ins[sxu_pkg::SIZE_BIT])
        begin
            d.size = sxu_pkg::SZ_WORD; // RL15
        end
        else
        begin
            d.size = sxu_pkg::SZ_BYTE; // RL15
        end
        if (grp == sxu_pkg::GRP_REG)
        begin
            d.mode = sxu_pkg::SRC_REG_MODE;
        end
        else if (grp == sxu_pkg::GRP_IMM_PTR)
        begin
            d.mode = zero_src ? sxu_pkg::LITERAL_OPERAND_MODE : sxu_pkg::POINTER_REG_MODE; // RL12
        end
        else
        begin
            d.mode = zero_src ? sxu_pkg::DIRECT_ADDRESS_MODE : sxu_pkg::INDEXED_MODE; // RL14
        end
        unique case (d.mode)
            sxu_pkg::SRC_REG_MODE:
                d.cycles = is_long ? sxu_pkg::CYC_REG_L : sxu_pkg::CYC_REG_BW; // RL10
            sxu_pkg::LITERAL_OPERAND_MODE:
                d.cycles = is_long ? sxu_pkg::CYC_LIT_L : sxu_pkg::CYC_LIT_BW; // RL11
            sxu_pkg::POINTER_REG_MODE:
                d.cycles = is_long ? sxu_pkg::CYC_PTR_L : sxu_pkg::CYC_PTR_BW; // RL12
            sxu_pkg::DIRECT_ADDRESS_MODE:
                if (!seg)
                    d.cycles = is_long ? sxu_pkg::CYC_DIR_NS_L : sxu_pkg::CYC_DIR_NS_BW; // RL13
                else if (!seg_long)
                    d.cycles = is_long ? sxu_pkg::CYC_DIR_SS_L : sxu_pkg::CYC_DIR_SS_BW; // RL13
                else
                    d.cycles = is_long ? sxu_pkg::CYC_DIR_SL_L : sxu_pkg::CYC_DIR_SL_BW; // RL13
            sxu_pkg::INDEXED_MODE:
                if (!seg)
                    d.cycles = is_long ? sxu_pkg::CYC_IDX_NS_L : sxu_pkg::CYC_IDX_NS_BW; // RL14
                else if (!seg_long)
                    d.cycles = is_long ? sxu_pkg::CYC_IDX_SS_L : sxu_pkg::CYC_IDX_SS_BW; // RL14
                else
                    d.cycles = is_long ? sxu_pkg::CYC_IDX_SL_L : sxu_pkg::CYC_IDX_SL_BW; // RL14
        endcase
        return d;
    endfunction : decode

    sxu_pkg::sxu_decode_type dec;
    sxu_pkg::sxu_state_type state_ff;
    logic [4:0] cnt_ff;
    logic accept;
    logic go;
    logic finish;
    logic [31:0] diff;
    sxu_pkg::sxu_flags_type new_flags;
    logic [31:0] res_ff;
    sxu_pkg::sxu_flags_type res_flags_ff;
    logic [3:0] dst_ff;
    sxu_pkg::sxu_size_type size_ff;

    assign dec = decode(i_instr, i_ext_word, i_seg_mode);
    assign accept = i_start && (state_ff == sxu_pkg::ST_IDLE);
    assign go = accept && dec.legal;
    assign finish = (state_ff == sxu_pkg::ST_BUSY) && (cnt_ff == sxu_pkg::CNT_LAST);

    sxu_adder u_adder
    (
        .i_a(i_dst_val),
        .i_b(i_src_val),
        .i_size(dec.size),
        .o_diff(diff),
        .o_flags(new_flags)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Sequencing: a start while busy is ignored
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_resetn)
        begin
            state_ff <= sxu_pkg::ST_IDLE;
            cnt_ff <= 5'h00;
        end
        else if (go)
        begin
            // Loaded one short: the registered done output supplies the last cycle
            state_ff <= sxu_pkg::ST_BUSY;
            cnt_ff <= dec.cycles - sxu_pkg::CNT_LAST; // RL10 RL11 RL12 RL13 RL14
        end
        else if (state_ff == sxu_pkg::ST_BUSY)
        begin
            cnt_ff <= cnt_ff - 5'h01;
            if (finish)
            begin
                state_ff <= sxu_pkg::ST_IDLE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Result held from start; operands may change after acceptance
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_resetn)
        begin
            res_ff <= 32'h00000000;
            res_flags_ff <= '0;
            dst_ff <= 4'h0;
            size_ff <= sxu_pkg::SZ_BYTE;
        end
        else if (go)
        begin
            res_ff <= diff; // RL1
            res_flags_ff <= new_flags;
            dst_ff <= dec.dst;
            size_ff <= dec.size;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_resetn)
        begin
            o_busy <= 1'b0;
            o_done <= 1'b0;
            o_illegal <= 1'b0;
            o_src_mode <= sxu_pkg::SRC_REG_MODE;
        end
        else
        begin
            o_busy <= go || ((state_ff == sxu_pkg::ST_BUSY) && !finish);
            o_done <= finish;
            o_illegal <= accept && !dec.legal;
            if (go)
            begin
                o_src_mode <= dec.mode;
            end
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_resetn)
        begin
            o_wr <= '0;
            o_flags <= '0;
            o_flags_we <= 1'b0;
            o_dh_we <= 1'b0;
        end
        else
        begin
            o_wr.en <= finish; // RL1
            o_flags_we <= finish;
            o_dh_we <= finish && (size_ff == sxu_pkg::SZ_BYTE); // RL7 RL8
            if (finish)
            begin
                o_wr.dst <= dst_ff; // RL9
                o_wr.size <= size_ff;
                o_wr.data <= res_ff;
                o_flags <= res_flags_ff;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks; the helper copies operands independently of the datapath
    logic [31:0] chk_a_ff;
    logic [31:0] chk_b_ff;
    sxu_pkg::sxu_size_type chk_size_ff;
    logic [3:0] chk_dst_ff;

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_resetn)
        begin
            chk_a_ff <= 32'h00000000;
            chk_b_ff <= 32'h00000000;
            chk_size_ff <= sxu_pkg::SZ_BYTE;
            chk_dst_ff <= 4'h0;
        end
        else if (go)
        begin
            chk_a_ff <= i_dst_val;
            chk_b_ff <= i_src_val;
            chk_size_ff <= dec.size;
            chk_dst_ff <= i_instr[sxu_pkg::DST_MSB:sxu_pkg::DST_LSB];
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);

    sequence reg_bw_go;
        go && dec.mode == sxu_pkg::SRC_REG_MODE && dec.size != sxu_pkg::SZ_LONG;
    endsequence
    sequence reg_long_go;
        go && dec.mode == sxu_pkg::SRC_REG_MODE && dec.size == sxu_pkg::SZ_LONG;
    endsequence
    sequence lit_long_go;
        go && dec.mode == sxu_pkg::LITERAL_OPERAND_MODE && dec.size == sxu_pkg::SZ_LONG;
    endsequence
    sequence dir_sl_bw_go;
        go && dec.mode == sxu_pkg::DIRECT_ADDRESS_MODE && i_seg_mode && i_ext_word[sxu_pkg::SEG_FORM_BIT]
            && dec.size != sxu_pkg::SZ_LONG;
    endsequence
    sequence idx_ns_long_go;
        go && dec.mode == sxu_pkg::INDEXED_MODE && !i_seg_mode && dec.size == sxu_pkg::SZ_LONG;
    endsequence

    diff_value_a: assert property (o_wr.en |-> o_wr.data == sxu_pkg::size_mask(chk_a_ff - chk_b_ff, chk_size_ff)) // RL1
        else $error("written difference wrong");
    dest_field_a: assert property (o_wr.en |-> o_wr.dst == chk_dst_ff) // RL9
        else $error("wrong destination register");
    borrow_flag_a: assert property (o_flags_we |-> o_flags.c ==
        (sxu_pkg::size_mask(chk_a_ff, chk_size_ff) < sxu_pkg::size_mask(chk_b_ff, chk_size_ff))) // RL3
        else $error("carry flag is not the borrow");
    zero_flag_a: assert property (o_flags_we |-> o_flags.z == (o_wr.data == 32'h00000000)) // RL4
        else $error("zero flag wrong");
    sign_flag_a: assert property (o_flags_we |-> o_flags.s == sxu_pkg::size_msb(o_wr.data, o_wr.size)) // RL5
        else $error("sign flag wrong");
    overflow_flag_a: assert property (o_flags_we |-> o_flags.v ==
        ((sxu_pkg::size_msb(chk_a_ff, chk_size_ff) != sxu_pkg::size_msb(chk_b_ff, chk_size_ff))
        && (sxu_pkg::size_msb(o_wr.data, chk_size_ff) == sxu_pkg::size_msb(chk_b_ff, chk_size_ff)))) // RL6
        else $error("overflow flag wrong");
    dadj_byte_a: assert property (o_flags_we |-> (o_dh_we == (chk_size_ff == sxu_pkg::SZ_BYTE))
        && (!o_dh_we || o_flags.d)) // RL7
        else $error("decimal adjust update wrong");
    half_borrow_a: assert property (o_dh_we |-> o_flags.h == (chk_a_ff[3:0] < chk_b_ff[3:0])) // RL8
        else $error("half carry flag wrong");
    word_size_a: assert property (go && dec.size != sxu_pkg::SZ_LONG |=> size_ff ==
        ($past(i_instr[sxu_pkg::SIZE_BIT]) ? sxu_pkg::SZ_WORD : sxu_pkg::SZ_BYTE)) // RL15
        else $error("size bit decoded wrong");
    reg_time_a: assert property (reg_bw_go |=> !o_done [*3] ##1 o_done) // RL10
        else $error("register form not 4 cycles");
    reg_long_time_a: assert property (reg_long_go |=> !o_done [*7] ##1 o_done) // RL10
        else $error("long register form not 8 cycles");
    lit_long_time_a: assert property (lit_long_go |-> ##14 o_done) // RL11
        else $error("long immediate form not 14 cycles");
    dir_seg_time_a: assert property (dir_sl_bw_go |-> ##12 o_done) // RL13 RL16
        else $error("long segment direct form not 12 cycles");
    idx_long_time_a: assert property (idx_ns_long_go |-> ##16 o_done) // RL14
        else $error("long indexed form not 16 cycles");

endmodule : sxu_core

// ==== testbench/sxu_regfile_model.sv ====
// Register file and flag register that sit behind the subtract unit.
// Assumes writes arrive from the unit as registered one-cycle pulses.
`timescale 1ns/1ps
module sxu_regfile_model
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    // Preload and readback
    input wire logic i_load_en,
    input wire logic [3:0] i_idx,
    input wire logic [31:0] i_load_val,
    output logic [31:0] o_rd_val,
    output sxu_pkg::sxu_flags_type o_flag_reg,
    // Unit writes
    input wire sxu_pkg::sxu_write_type i_wr,
    input wire sxu_pkg::sxu_flags_type i_flags,
    input wire logic i_flags_we,
    input wire logic i_dh_we
);
    logic [31:0] regs_ff [16];

    assign o_rd_val = regs_ff[i_idx];

    ////////////////////////////////////////////////////////////////////////////
    // Registers are left unreset; the bench loads every one it reads
    always_ff @(posedge i_clk_sys)
    begin
        if (i_load_en)
        begin
            regs_ff[i_idx] <= i_load_val;
        end
        if (i_wr.en)
        begin
            regs_ff[i_wr.dst] <= i_wr.data;
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_resetn)
        begin
            o_flag_reg <= '0;
        end
        else
        begin
            if (i_flags_we)
            begin
                o_flag_reg[5:2] <= i_flags[5:2];
            end
            if (i_dh_we)
            begin
                o_flag_reg[1:0] <= i_flags[1:0];
            end
        end
    end
endmodule : sxu_regfile_model

// ==== testbench/testbench.sv ====
// Self-checking bench for the subtract execution unit.
// Assumes sxu_core and the register file model; the bench plays the decoder.
`timescale 1ns/1ps
module testbench;
    logic i_clk_sys = 1'b0;
    logic i_resetn = 1'b0;
    logic i_start = 1'b0;
    logic [15:0] i_instr = 16'h0000;
    logic [15:0] i_ext_word = 16'h0000;
    logic i_seg_mode = 1'b0;
    logic [31:0] i_dst_val = 32'h0;
    logic [31:0] i_src_val = 32'h0;
    logic o_busy, o_done, o_illegal, o_flags_we, o_dh_we;
    sxu_pkg::sxu_src_type o_src_mode;
    sxu_pkg::sxu_write_type o_wr;
    sxu_pkg::sxu_flags_type o_flags, flag_reg;
    sxu_pkg::sxu_flags_type exp_reg = '0;
    logic load_en = 1'b0;
    logic [3:0] idx = 4'h0;
    logic [31:0] load_val = 32'h0;
    logic [31:0] rd_val;
    int bad_count = 0;
    int checked = 0;
    int cycles = 0;
    int seed = 32'h8f22;

    always #25 i_clk_sys = ~i_clk_sys;

    sxu_core uut
    (
        .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_start(i_start), .i_instr(i_instr),
        .i_ext_word(i_ext_word), .i_seg_mode(i_seg_mode), .i_dst_val(i_dst_val), .i_src_val(i_src_val),
        .o_busy(o_busy), .o_done(o_done), .o_illegal(o_illegal), .o_src_mode(o_src_mode),
        .o_wr(o_wr), .o_flags(o_flags), .o_flags_we(o_flags_we), .o_dh_we(o_dh_we)
    );

    sxu_regfile_model mdl
    (
        .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_load_en(load_en), .i_idx(idx),
        .i_load_val(load_val), .o_rd_val(rd_val), .o_flag_reg(flag_reg), .i_wr(o_wr),
        .i_flags(o_flags), .i_flags_we(o_flags_we), .i_dh_we(o_dh_we)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
        begin
            $display("All tests passed");
        end
        else
        begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run

    // A run of 53 instructions needs under 2000 cycles
    always @(posedge i_clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            bad_count++;
            complete_run();
        end
    end

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            $display("unexpected %s expected %h seen %h", name, exp, got);
            bad_count++;
        end
    endtask : check

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [4:0] exp_cyc(input int m, input logic l, input int f);
        case (m)
            0: return l ? 5'h08 : 5'h04;
            1, 2: return l ? 5'h0e : 5'h07;
            3: return (f == 0) ? (l ? 5'h0f : 5'h09) : (f == 1) ? (l ? 5'h10 : 5'h0a) : (l ? 5'h12 : 5'h0c);
            default: return (f == 2) ? (l ? 5'h13 : 5'h0d) : (l ? 5'h10 : 5'h0a);
        endcase
    endfunction : exp_cyc

    function automatic logic [15:0] mk_instr(input int m, input sxu_pkg::sxu_size_type sz,
                                             input logic [3:0] s, input logic [3:0] d);
        logic [1:0] g;
        logic [5:0] body;
        g = (m == 0) ? 2'h2 : (m < 3) ? 2'h0 : 2'h1;
        body = (sz == sxu_pkg::SZ_LONG) ? 6'h12 : {5'h01, sz == sxu_pkg::SZ_WORD};
        return {g, body, (m == 1 || m == 3) ? 4'h0 : s, d};
    endfunction : mk_instr

    // Borrow flags are the inverse of the adder carries
    function automatic void sub_model(input logic [31:0] a, input logic [31:0] b, input sxu_pkg::sxu_size_type sz,
                                      output logic [31:0] r, output sxu_pkg::sxu_flags_type f);
        logic [32:0] t;
        logic [4:0] nb;
        logic [31:0] mk;
        int w;
        w = (sz == sxu_pkg::SZ_BYTE) ? 8 : (sz == sxu_pkg::SZ_WORD) ? 16 : 32;
        mk = (w == 32) ? 32'hffffffff : (32'h1 << w) - 32'h1;
        t = {1'b0, a & mk} + {1'b0, ~b & mk} + 33'h1;
        r = t[31:0] & mk;
        nb = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h1;
        f.c = !t[w];
        f.z = (r == 32'h0);
        f.s = r[w-1];
        f.v = (a[w-1] != b[w-1]) && (r[w-1] == b[w-1]);
        f.d = 1'b1;
        f.h = !nb[4];
    endfunction : sub_model

    ////////////////////////////////////////////////////////////////////////////
    // f: 0 nonsegmented, 1 segmented short address, 2 segmented long address
    task automatic run(input int m, input sxu_pkg::sxu_size_type sz, input int f,
                       input logic [31:0] a, input logic [31:0] b);
        logic [3:0] d;
        logic [3:0] s;
        logic [31:0] r;
        sxu_pkg::sxu_flags_type ef;
        int k;
        d = 4'($random(seed));
        s = (d == 4'hf) ? 4'h5 : d + 4'h1;
        sub_model(a, b, sz, r, ef);
        @(posedge i_clk_sys);
        load_en <= 1'b1;
        idx <= d;
        load_val <= a;
        @(posedge i_clk_sys);
        idx <= s;
        load_val <= b;
        @(posedge i_clk_sys);
        load_en <= 1'b0;
        i_start <= 1'b1;
        i_instr <= mk_instr(m, sz, s, d);
        i_ext_word <= {f == 2, 15'($random(seed))};
        i_seg_mode <= (f != 0);
        i_dst_val <= a;
        i_src_val <= b;
        // A second start while busy must be dropped without a trace
        for (k = 1; k < 30; k++)
        begin
            @(posedge i_clk_sys);
            i_start <= (k == 2);
            i_instr <= 16'hc000;
            #1;
            if (o_done === 1'b1 || o_illegal === 1'b1)
            begin
                break;
            end
            check("busy", 32'h1, 32'(o_busy));
        end
        check("cycles", 32'(exp_cyc(m, sz == sxu_pkg::SZ_LONG, f)), k);
        check("illegal", 32'h0, 32'(o_illegal));
        check("done", 32'h3, {o_wr.en, o_flags_we});
        check("write dst", 32'(d), 32'(o_wr.dst));
        check("write size", 32'(sz), 32'(o_wr.size));
        check("result", r, o_wr.data);
        check("flags", 32'(ef[5:2]), 32'(o_flags[5:2]));
        check("dh write", 32'(sz == sxu_pkg::SZ_BYTE), 32'(o_dh_we));
        check("mode", 32'(m), 32'(o_src_mode));
        exp_reg = (sz == sxu_pkg::SZ_BYTE) ? ef : {ef[5:2], exp_reg[1:0]};
        @(posedge i_clk_sys);
        idx <= d;
        #1;
        check("flag reg", 32'(exp_reg), 32'(flag_reg));
        check("dest reg", r, rd_val);
        @(posedge i_clk_sys);
        idx <= s;
        #1;
        check("source reg", b, rd_val);
    endtask : run

    task automatic bad_op(input logic [15:0] op);
        @(posedge i_clk_sys);
        i_start <= 1'b1;
        i_instr <= op;
        @(posedge i_clk_sys);
        i_start <= 1'b0;
        #1;
        check("illegal op", 32'h2, {o_illegal, o_wr.en});
        @(posedge i_clk_sys);
        #1;
        check("illegal end", 32'h0, {o_illegal, o_done, o_busy});
    endtask : bad_op

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20) @(posedge i_clk_sys);
        #1;
        check("reset out", 32'h0, {o_busy, o_done, o_wr.en, o_flags_we, o_dh_we, o_flags, o_src_mode});
        @(posedge i_clk_sys);
        i_resetn <= 1'b1;
        run(1, sxu_pkg::SZ_WORD, 0, 32'h0344, 32'h00aa);
        run(0, sxu_pkg::SZ_BYTE, 1, 32'hff80, 32'h0001);
        run(2, sxu_pkg::SZ_BYTE, 2, 32'h0010, 32'h0001);
        run(3, sxu_pkg::SZ_LONG, 2, 32'h0, 32'h1);
        run(4, sxu_pkg::SZ_WORD, 1, 32'h1234, 32'h1234);
        run(0, sxu_pkg::SZ_WORD, 0, 32'h7fff, 32'hffff);
        bad_op(16'hc123);
        bad_op(16'h8e45);
        for (int m = 0; m < 5; m++)
        begin
            for (int z = 0; z < 3; z++)
            begin
                for (int f = 0; f < 3; f++)
                begin
                    run(m, sxu_pkg::sxu_size_type'(z), f, $random(seed), $random(seed));
                end
            end
        end
        complete_run();
    end
endmodule : testbench
